// [dgcs_global_cmd_status.sv]
// Implementation choice: strobed register access.
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// R1: Poll bits self-clear and act only when chain-end select is zero.
// R2: Poll bits for channels 3..0 sit at command bits 13..10, reset zero.
// R3: With chain-end select zero, a transmit channel stops on a set hold bit.
// R4: Poll while held re-reads descriptor words 0 and 1.
// R5: Hold found clear after re-read moves to next descriptor.
// R6: Poll written while not held is discarded.
// R7: Command bit 9 is action interrupt mask, resets to one.
// R8: Command bit 0 self-clears and launches the action request.
// R9: Reserved command and status bits read as zero.
// R10: Status reports action result and which queue got vectors.
// R11: Nine vector queues: four receive, four transmit, one config.
// R12: Host clears status bits by writing one to them.
// R13: Interrupt asserts while any indication bit is set.
// R14: Interrupt deasserts only when all indication bits are clear.
// R15: Status bits 31..28 flag new receive queue vectors, channels 3..0.
// R16: Status bits 27..24 flag new transmit queue vectors, channels 3..0.
// R17: Mode bit 0 selects hold-bit control at zero, address at one.
// R18: Status bit 21 flags new configuration queue vectors.
// R19: Status bit 1 flags action failure, bit 0 action success.
// R20: A queue event beats a simultaneous host clear.
// R21: Self-clearing command bits read zero one clock after the write.
module dgcs_global_cmd_status
  import dgcs_pkg::*;
(
  // Clock and reset.
  input  wire logic        REF_CLK,
  input  wire logic        RESET,
  // Register port.
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output var  logic [31:0] RDATA,
  // Events from the DMA engine.
  input  wire logic [3:0]  RX_QUEUE_EVT,
  input  wire logic [3:0]  TX_QUEUE_EVT,
  input  wire logic        CFG_QUEUE_EVT,
  input  wire logic        ACTION_OK,
  input  wire logic        ACTION_FAIL,
  // Transmit descriptor handshake per channel.
  input  wire logic [3:0]  TX_HOLD_SEEN,
  input  wire logic [3:0]  TX_REREAD_DONE,
  input  wire logic [3:0]  TX_HOLD_BIT,
  output var  logic [3:0]  TX_REREAD_REQ,
  output var  logic [3:0]  TX_NEXT_DESC,
  output var  logic [3:0]  TX_STOPPED,
  // Action request launch.
  output var  logic        ACTION_GO,
  output var  logic [10:0] ACTION_CFG,
  output var  logic        CHAIN_END_SELECT,
  // Interrupt, active low.
  output var  logic        INTA_N
);

  dgcs_bus_t   bus;
  dgcs_evt_t   evt;
  logic [31:0] status_ff;
  logic [31:0] nxt_status;
  logic [31:0] cmd_rd;
  logic [10:0] cfg_ff;
  logic        mask_ff;
  logic        chain_ff;
  logic        go_ff;
  logic [3:0]  poll_pulse;
  logic [31:0] rdata_ff;
  logic        inta_n_ff;
  logic [31:0] ind_mask;
  logic        any_ind;

  assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
  assign evt = '{rx_evt: RX_QUEUE_EVT, tx_evt: TX_QUEUE_EVT,
                 cfg_evt: CFG_QUEUE_EVT, ok_evt: ACTION_OK,
                 fail_evt: ACTION_FAIL};

  // Stored command fields; poll and action bits are never stored.
  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      cfg_ff  <= '0;
      mask_ff <= MASK_RST;
    end
    else if (bus.wr && bus.addr == GLOBAL_COMMAND_OFS)
    begin
      cfg_ff  <= bus.wdata[CMD_CFG_LSB +: CMD_CFG_BITS];
      // R7: mask write
      mask_ff <= bus.wdata[CMD_MASK_BIT];
    end
  end

  // Mode register.
  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
      chain_ff <= 1'b0;
    // R17: chain-end select
    else if (bus.wr && bus.addr == GLOBAL_MODE_OFS)
      chain_ff <= bus.wdata[MODE_CHAIN_BIT];
  end

  // R8: action request pulse
  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
      go_ff <= 1'b0;
    else
      go_ff <= bus.wr && bus.addr == GLOBAL_COMMAND_OFS
               && bus.wdata[CMD_ACTION_BIT];
  end

  // R1: poll gated by mode
  // R2: poll bits 13..10
  assign poll_pulse = (bus.wr && bus.addr == GLOBAL_COMMAND_OFS
                       && !chain_ff)
                      ? bus.wdata[CMD_POLL_LSB +: NUM_CH] : 4'h0;

  // One hold state machine per transmit channel.
  generate
    for (genvar c = 0; c < NUM_CH; c++)
    begin : g_tx
      dgcs_txst_t st_ff;
      dgcs_txst_t nxt_st;
      logic       reread_ff;
      logic       next_ff;

      always_comb
      begin
        nxt_st = st_ff;
        case (st_ff)
          ST_RUN:
            // R3: stop on hold
            if (TX_HOLD_SEEN[c] && !chain_ff)
              nxt_st = ST_HELD;
          ST_HELD:
            // R4: re-read on poll
            if (poll_pulse[c])
              nxt_st = ST_REREAD;
          ST_REREAD:
            if (TX_REREAD_DONE[c])
              // R5: advance if clear
              nxt_st = TX_HOLD_BIT[c] ? ST_HELD : ST_RUN;
          default:
            nxt_st = ST_RUN;
        endcase
      end

      always_ff @(posedge REF_CLK)
      begin
        if (RESET)
        begin
          st_ff     <= ST_RUN;
          reread_ff <= 1'b0;
          next_ff   <= 1'b0;
        end
        else
        begin
          st_ff     <= nxt_st;
          // R6: poll ignored unless held
          reread_ff <= (st_ff == ST_HELD) && poll_pulse[c];
          next_ff   <= (st_ff == ST_REREAD) && TX_REREAD_DONE[c]
                       && !TX_HOLD_BIT[c];
        end
      end

      assign TX_REREAD_REQ[c] = reread_ff;
      assign TX_NEXT_DESC[c]  = next_ff;
      assign TX_STOPPED[c]    = st_ff[1];

      // R6: no reread outside held
      a_poll_ignored: assert property (@(posedge REF_CLK) disable iff (RESET)
        (poll_pulse[c] && st_ff != ST_HELD) |=> !reread_ff) // R6
        else $error("poll acted outside held state");
      // R5: next descriptor after clear
      a_next_desc: assert property (@(posedge REF_CLK) disable iff (RESET)
        (st_ff == ST_REREAD && TX_REREAD_DONE[c] && !TX_HOLD_BIT[c])
        |=> next_ff && st_ff == ST_RUN) // R5
        else $error("no advance after hold cleared");
      // R3: stop on hold seen
      a_stop_hold: assert property (@(posedge REF_CLK) disable iff (RESET)
        (st_ff == ST_RUN && TX_HOLD_SEEN[c] && !chain_ff)
        |=> TX_STOPPED[c]) // R3
        else $error("channel did not stop on hold");
    end
  endgenerate

  // Indication bits that drive the interrupt.
  assign ind_mask = {{NUM_CH{1'b1}}, {NUM_CH{1'b1}}, 2'b00, 1'b1, 19'h0_0000,
                     2'b00};

  // R12: write one to clear, R20: set wins
  always_comb
  begin
    nxt_status = status_ff;
    if (bus.wr && bus.addr == GLOBAL_STATUS_OFS)
      nxt_status = status_ff & ~bus.wdata;
    // R15: receive queue flags
    nxt_status[STS_RX_LSB +: NUM_CH] = nxt_status[STS_RX_LSB +: NUM_CH]
                                       | evt.rx_evt;
    // R16: transmit queue flags
    nxt_status[STS_TX_LSB +: NUM_CH] = nxt_status[STS_TX_LSB +: NUM_CH]
                                       | evt.tx_evt;
    // R18: config queue flag
    nxt_status[STS_CFG_BIT] = nxt_status[STS_CFG_BIT] | evt.cfg_evt;
    // R19: action result flags
    nxt_status[STS_OK_BIT]   = nxt_status[STS_OK_BIT] | evt.ok_evt;
    nxt_status[STS_FAIL_BIT] = nxt_status[STS_FAIL_BIT] | evt.fail_evt;
  end

  // R10: status register, R11 nine queue flags
  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
      status_ff <= ZERO_WORD;
    else
      status_ff <= nxt_status;
  end

  // Action result bits raise the interrupt only when unmasked.
  assign any_ind = |(status_ff & ind_mask)
                   | (!mask_ff && |status_ff[STS_FAIL_BIT:STS_OK_BIT]);

  // R13: assert on any queue flag or unmasked action flag, R14: release when all clear
  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
      inta_n_ff <= 1'b1;
    else
      inta_n_ff <= !any_ind;
  end

  // R9: reserved zero, R21: self-clearing bits read zero
  assign cmd_rd = {cfg_ff, 7'h00, 4'h0, mask_ff, 8'h00, 1'b0};

  // Read data appear in the cycle after the strobe only.
  always_ff @(posedge REF_CLK)
  begin
    if (RESET || !bus.rd)
      rdata_ff <= ZERO_WORD;
    else
      case (bus.addr)
        GLOBAL_COMMAND_OFS: rdata_ff <= cmd_rd;
        GLOBAL_STATUS_OFS:  rdata_ff <= status_ff;
        GLOBAL_MODE_OFS:    rdata_ff <= {31'h0000_0000, chain_ff};
        default:            rdata_ff <= ZERO_WORD;
      endcase
  end

  assign RDATA            = rdata_ff;
  assign INTA_N           = inta_n_ff;
  assign ACTION_GO        = go_ff;
  assign ACTION_CFG       = cfg_ff;
  assign CHAIN_END_SELECT = chain_ff;

  // R20: event survives a clear
  a_set_wins: assert property (@(posedge REF_CLK) disable iff (RESET)
    evt.rx_evt[0] |=> status_ff[STS_RX_LSB]) // R20
    else $error("receive flag lost");
  // R12: written ones clear
  a_w1c_clear: assert property (@(posedge REF_CLK) disable iff (RESET)
    (bus.wr && bus.addr == GLOBAL_STATUS_OFS && bus.wdata[STS_CFG_BIT]
     && !evt.cfg_evt) |=> !status_ff[STS_CFG_BIT]) // R12
    else $error("config flag not cleared");
  // R13: interrupt follows flags
  a_irq_assert: assert property (@(posedge REF_CLK) disable iff (RESET)
    (|status_ff[31:24]) |=> !INTA_N) // R13
    else $error("interrupt not raised");
  // R14: interrupt released when clear
  a_irq_release: assert property (@(posedge REF_CLK) disable iff (RESET)
    (status_ff == ZERO_WORD) |=> INTA_N) // R14
    else $error("interrupt held without flags");
  // R8: action pulse one cycle
  // A second action write right behind the first legally keeps it high.
  a_action_pulse: assert property (@(posedge REF_CLK) disable iff (RESET)
    (bus.wr && bus.addr == GLOBAL_COMMAND_OFS && bus.wdata[CMD_ACTION_BIT])
    |=> ACTION_GO ##1 (!ACTION_GO
                       || $past(bus.wr && bus.addr == GLOBAL_COMMAND_OFS
                                && bus.wdata[CMD_ACTION_BIT]))) // R8
    else $error("action pulse wrong");
  // R1: no poll in address mode
  a_poll_mode: assert property (@(posedge REF_CLK) disable iff (RESET)
    chain_ff |-> poll_pulse == 4'h0) // R1
    else $error("poll in address mode");
  // R9: reserved status bits zero
  a_reserved_zero: assert property (@(posedge REF_CLK) disable iff (RESET)
    status_ff[23:22] == 2'b00 && status_ff[20:2] == 19'h0_0000) // R9
    else $error("reserved status bits set");
  // R7: mask resets to one
  a_mask_reset: assert property (@(posedge REF_CLK)
    RESET |=> mask_ff) // R7
    else $error("mask reset wrong");
  // R20: clear loses to event
  a_clear_loses: assert property (@(posedge REF_CLK) disable iff (RESET)
    (bus.wr && bus.addr == GLOBAL_STATUS_OFS && evt.rx_evt[NUM_CH-1])
    |=> status_ff[STS_RX_LSB+NUM_CH-1]) // R20
    else $error("receive flag lost to clear");
  // R13: config flag raises interrupt
  a_irq_cfg: assert property (@(posedge REF_CLK) disable iff (RESET)
    status_ff[STS_CFG_BIT] |=> !INTA_N) // R13
    else $error("config flag did not raise interrupt");
  // R19: failure flag sets
  a_fail_flag: assert property (@(posedge REF_CLK) disable iff (RESET)
    evt.fail_evt |=> status_ff[STS_FAIL_BIT]) // R19
    else $error("failure flag not set");

endmodule : dgcs_global_cmd_status

`default_nettype wire

// [dgcs_pkg.sv]
package dgcs_pkg;

  // Register byte offsets; the command word sits at the bottom of the map.
  localparam logic [7:0] GLOBAL_COMMAND_OFS = 8'h00;
  localparam logic [7:0] GLOBAL_STATUS_OFS  = 8'h04;
  localparam logic [7:0] GLOBAL_MODE_OFS    = 8'h08;

  // Command field positions.
  localparam int CMD_ACTION_BIT = 0;
  localparam int CMD_MASK_BIT   = 9;
  localparam int CMD_POLL_LSB   = 10;
  localparam int CMD_CFG_LSB    = 21;
  localparam int CMD_CFG_BITS   = 11;

  // Status field positions.
  localparam int STS_OK_BIT   = 0;
  localparam int STS_FAIL_BIT = 1;
  localparam int STS_CFG_BIT  = 21;
  localparam int STS_TX_LSB   = 24;
  localparam int STS_RX_LSB   = 28;

  // Mode field position, channel count and reset values.
  localparam int         MODE_CHAIN_BIT = 0;
  localparam int         NUM_CH         = 4;
  localparam logic       MASK_RST       = 1'b1;
  localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;

  // One host register access.
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } dgcs_bus_t;

  // Queue and action events reported by the DMA engine, one cycle each.
  typedef struct packed {
    logic [3:0] rx_evt;
    logic [3:0] tx_evt;
    logic       cfg_evt;
    logic       ok_evt;
    logic       fail_evt;
  } dgcs_evt_t;

  // Per-channel transmit hold state.
  typedef enum logic [2:0] {
    ST_RUN   = 3'b001,
    ST_HELD  = 3'b010,
    ST_REREAD = 3'b100
  } dgcs_txst_t;

endpackage : dgcs_pkg

// [dgcs_engine_model.sv]
`timescale 1ns/10ps
`default_nettype none

// Descriptor fetch side of the transmit engine.
module dgcs_engine_model
(
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst,
  // Re-read handshake.
  input  wire logic [3:0] reread_req,
  input  wire logic [3:0] hold_cfg,
  output logic      [3:0] reread_done,
  output logic      [3:0] hold_bit
);
  // answer one cycle later.
  // Between answers the hold value flips, so a late sample shows up.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      reread_done <= 4'h0;
      hold_bit    <= 4'h0;
    end
    else
    begin
      reread_done <= reread_req;
      hold_bit    <= (reread_req != 4'h0) ? hold_cfg : ~hold_bit;
    end
  end
endmodule : dgcs_engine_model

`default_nettype wire

// [tb.sv]
`timescale 1ns/10ps
`default_nettype none

module tb;
  import dgcs_pkg::*;
  localparam logic [7:0] CMD = GLOBAL_COMMAND_OFS;
  localparam logic [7:0] STS = GLOBAL_STATUS_OFS;
  localparam logic [7:0] MDE = GLOBAL_MODE_OFS;
  logic        clk = 0, rst = 1, wr = 0, rd = 0, cfge = 0, aok = 0;
  logic        afail = 0, go, ces, inta_n;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic [3:0]  rxe = 0, txe = 0, seen = 0, hcfg = 0, done, hbit;
  logic [3:0]  req, nxt, stp;
  logic [10:0] cfg;
  int          miscompares = 0, num_checks = 0, cyc = 0;

  // Free-running clock, 8 ns period.
  always #4 clk = ~clk;

  dgcs_global_cmd_status u_dut (
    .REF_CLK(clk), .RESET(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .RX_QUEUE_EVT(rxe), .TX_QUEUE_EVT(txe),
    .CFG_QUEUE_EVT(cfge), .ACTION_OK(aok), .ACTION_FAIL(afail),
    .TX_HOLD_SEEN(seen), .TX_REREAD_DONE(done), .TX_HOLD_BIT(hbit),
    .TX_REREAD_REQ(req), .TX_NEXT_DESC(nxt), .TX_STOPPED(stp),
    .ACTION_GO(go), .ACTION_CFG(cfg), .CHAIN_END_SELECT(ces),
    .INTA_N(inta_n));

  dgcs_engine_model u_eng (
    .clk(clk), .rst(rst), .reread_req(req), .hold_cfg(hcfg),
    .reread_done(done), .hold_bit(hbit));

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict

  // A hang ends the run long after the scenarios should be done.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      miscompares++;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg

  // Read data stand only in the cycle after the strobe.
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask : rd_chk

  task automatic t_reset;
    #1 chk(inta_n, 1);
    rd_chk(CMD, 32'h0000_0200);
    rd_chk(STS, 32'h0000_0000);
    rd_chk(MDE, 32'h0000_0000);
    // Poll bits here hit idle channels and must do nothing.
    wr_reg(CMD, 32'hFFFF_FDFE);
    chk(req, 4'h0);
    rd_chk(CMD, 32'hFFE0_0000);
  endtask : t_reset

  task automatic t_events;
    @(posedge clk);
    rxe <= 4'hF; txe <= 4'hF; cfge <= 1'b1;
    @(posedge clk);
    rxe <= 4'h0; txe <= 4'h0; cfge <= 1'b0;
    @(posedge clk);
    #1 chk(inta_n, 0);
    rd_chk(STS, 32'hFF20_0000);
    wr_reg(STS, 32'h1000_0000);
    rd_chk(STS, 32'hEF20_0000);
    chk(inta_n, 0);
    // A clear meeting a new event on the same bit must lose.
    @(posedge clk);
    wr <= 1'b1; addr <= STS; wdata <= 32'h8000_0000; rxe <= 4'h8;
    @(posedge clk);
    wr <= 1'b0; rxe <= 4'h0;
    rd_chk(STS, 32'hEF20_0000);
    wr_reg(STS, 32'hFFFF_FFFF);
    rd_chk(STS, 32'h0000_0000);
    chk(inta_n, 1);
  endtask : t_events

  task automatic act(input logic ok, input logic [31:0] exp, input logic i);
    @(posedge clk);
    aok <= ok; afail <= ~ok;
    @(posedge clk);
    aok <= 1'b0; afail <= 1'b0;
    rd_chk(STS, exp);
    chk(inta_n, i);
    wr_reg(STS, exp);
  endtask : act

  task automatic t_action;
    wr_reg(CMD, 32'h0020_0001);
    chk(go, 1);
    chk(cfg, 11'h001);
    rd_chk(CMD, 32'h0020_0000);
    act(1'b1, 32'h0000_0001, 1'b0);
    wr_reg(CMD, 32'h0000_0200);
    chk(go, 0);
    act(1'b0, 32'h0000_0002, 1'b1);
  endtask : t_action

  task automatic poll_ch(input int c, input logic h);
    logic hit;
    hit = 1'b0;
    hcfg <= {4{h}};
    @(posedge clk);
    seen <= 4'h1 << c;
    @(posedge clk);
    seen <= 4'h0;
    #1 chk(stp[c], 1);
    wr_reg(CMD, 32'h0000_0200 | (32'h0000_0400 << c));
    chk(req, 4'h1 << c);
    repeat (4)
    begin
      @(posedge clk);
      #1 hit = hit | nxt[c];
    end
    chk(hit, !h);
    chk(stp[c], h);
  endtask : poll_ch

  task automatic t_mode;
    wr_reg(MDE, 32'h0000_0001);
    chk(ces, 1);
    @(posedge clk);
    seen <= 4'h4;
    @(posedge clk);
    seen <= 4'h0;
    #1 chk(stp, 4'hA);
    // Channel 3 is still held, so only the mode can refuse this poll.
    wr_reg(CMD, 32'h0000_2200);
    chk(req, 4'h0);
    rd_chk(MDE, 32'h0000_0001);
    wr_reg(MDE, 32'h0000_0000);
  endtask : t_mode

  // A reset in mid-run must drop held channels and flags and set the mask again.
  task automatic t_rerun;
    wr_reg(CMD, 32'hFFE0_0000);
    @(posedge clk);
    cfge <= 1'b1;
    @(posedge clk);
    cfge <= 1'b0;
    rst  <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1 chk(stp, 4'h0);
    chk(cfg, 11'h000);
    rd_chk(CMD, 32'h0000_0200);
    rd_chk(STS, 32'h0000_0000);
    chk(inta_n, 1);
  endtask : t_rerun

  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_events();
    t_action();
    for (int c = 0; c < NUM_CH; c++)
      poll_ch(c, c[0]);
    t_mode();
    t_rerun();
    give_verdict();
  end
endmodule : tb

`default_nettype wire
